// File: src/pec_consts.svh
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH

// ****************************************************************
// Mode field encodings.
// ****************************************************************
`define PEC_MODE_FIQ 5'h11
`define PEC_MODE_IRQ 5'h12
`define PEC_MODE_SVC 5'h13
`define PEC_MODE_MON 5'h16
`define PEC_MODE_ABT 5'h17

// ****************************************************************
// Status word field positions.
// ****************************************************************
`define PEC_SR_M_HI  4
`define PEC_SR_M_LO  0
`define PEC_SR_T     5
`define PEC_SR_F     6
`define PEC_SR_I     7
`define PEC_SR_A     8
`define PEC_SR_J     24

// ****************************************************************
// Secure configuration field positions.
// ****************************************************************
`define PEC_SC_NS    0
`define PEC_SC_IRQ   1
`define PEC_SC_FIQ   2
`define PEC_SC_EA    3
`define PEC_SC_FW    4
`define PEC_SC_AW    5
`define PEC_SC_W     6

// ****************************************************************
// Register port byte offsets.
// ****************************************************************
`define PEC_OFF_SCR  8'h00
`define PEC_OFF_CSR  8'h04
`define PEC_OFF_SSR  8'h08
`define PEC_OFF_FSR  8'h0C
`define PEC_OFF_LNK  8'h10

// ****************************************************************
// Fault status codes, one per fault class.
// ****************************************************************
`define PEC_FS_ALIGN 5'h01
`define PEC_FS_TRANS 5'h05
`define PEC_FS_ACCF  5'h03
`define PEC_FS_DOM   5'h09
`define PEC_FS_PERM  5'h0D
`define PEC_FS_CPIM  5'h04
`define PEC_FS_WATCH 5'h02
`define PEC_FS_CACHE 5'h18
`define PEC_FS_EXTP  5'h08
`define PEC_FS_EXTI  5'h16

// Reset value of every banked word and of the secure configuration.
`define PEC_ZERO32   32'h0000_0000

`endif

// File: src/pec_pkg.sv
`default_nettype none
package pec_pkg;
   // Internal fault class reported with a memory check data fault.
   typedef enum logic [2:0] {
      PEC_FLT_ALIGN = 3'h0,
      PEC_FLT_TRANS = 3'h1,
      PEC_FLT_ACCF  = 3'h2,
      PEC_FLT_DOM   = 3'h3,
      PEC_FLT_PERM  = 3'h4,
      PEC_FLT_CPIM  = 3'h5,
      PEC_FLT_WATCH = 3'h6,
      PEC_FLT_CACHE = 3'h7
   } pec_flt_t;

   // Exception taken, one-hot.
   typedef enum logic [5:0] {
      PEC_EXC_NONE = 6'h00,
      PEC_EXC_DABT = 6'h01,
      PEC_EXC_FIQ  = 6'h02,
      PEC_EXC_IRQ  = 6'h04,
      PEC_EXC_PABT = 6'h08,
      PEC_EXC_IABT = 6'h10,
      PEC_EXC_RET  = 6'h20
   } pec_exc_t;
endpackage : pec_pkg
`default_nettype wire

// File: src/pec_exception_entry.sv
`include "pec_consts.svh"
`default_nettype none
module pec_exception_entry #(
   parameter int ADDR_W = 32          // Program counter width.
) (
   input  wire logic              clk,          // Core clock.
   input  wire logic              rst_n,        // Async reset, low.
   input  wire logic              boot_state_select, // Boot state.
   input  wire logic              fast_interrupt_req_n, // Fast req.
   input  wire logic              normal_interrupt_req_n, // Normal.
   input  wire logic              instr_end,    // Instruction retires.
   input  wire logic [ADDR_W-1:0] cur_pc,       // Its address.
   input  wire logic              ex_fetch_bad, // Tagged invalid.
   input  wire logic              mem_fault,    // Memory check fault.
   input  wire pec_pkg::pec_flt_t mem_fault_cls, // Fault class.
   input  wire logic              ext_err,      // Bus error response.
   input  wire logic              ext_strong,   // Strongly ordered.
   input  wire logic              ext_ld_psr,   // Load to pc/status.
   input  wire logic              ext_swap_ld,  // Swap load part.
   input  wire logic              ext_cacheable, // Cacheable line.
   input  wire logic              ext_word_req, // Errored word asked.
   input  wire logic [31:0]       base_old,     // Base before instr.
   input  wire logic [31:0]       base_new,     // Updated base.
   input  wire logic              base_upd,     // Instr updates base.
   input  wire logic              ret_s_pc,     // Flag-set r15 write.
   input  wire logic [7:0]        reg_addr,     // Register address.
   input  wire logic [31:0]       reg_wdata,    // Write data.
   input  wire logic              reg_wr,       // Write strobe.
   input  wire logic              reg_rd,       // Read strobe.
   output logic [31:0]            reg_rdata,    // Read data.
   output logic [31:0]            status_out,   // Current status.
   output logic                   abandon,      // Abandon instr.
   output logic                   fetch_reset_vec, // Reset fetch.
   output logic                   exc_taken,    // Entry pulse.
   output pec_pkg::pec_exc_t      exc_kind,     // Entry kind.
   output logic                   base_wb,      // Base write pulse.
   output logic [31:0]            base_val      // Base value.
);
   // ****************************************************************
   // Elaboration checks.
   // ****************************************************************
   if (ADDR_W < 8 || ADDR_W > 32)
   begin : g_chk
      $error("ADDR_W out of range.");
   end

   // ****************************************************************
   // State.
   // ****************************************************************
   logic [31:0]       csr_ff;           // Current status word.
   logic [31:0]       scr_ff;           // Secure configuration.
   logic [31:0]       ssr_ff [5];       // Saved status per bank.
   logic [ADDR_W-1:0] lnk_ff [5];       // Link per bank.
   logic [4:0]        fsr_ff;           // Fault status code.
   logic              fiq_q_ff;         // Registered fast request.
   logic              irq_q_ff;         // Registered normal request.
   logic              imp_pend_ff;      // Pending imprecise abort.
   logic              boot_pend_ff;     // Reset just released.
   logic              abandon_ff;       // Abandon flag.
   logic              fetch_rv_ff;      // Reset vector fetch.
   logic              taken_ff;         // Entry pulse.
   pec_pkg::pec_exc_t kind_ff;          // Entry kind.
   logic              base_wb_ff;       // Base write pulse.
   logic [31:0]       base_val_ff;      // Base value.
   logic [31:0]       rdata_ff;         // Read data.

   // Bank index: 0 svc, 1 fiq, 2 irq, 3 abt, 4 mon.
   function automatic logic [2:0] bank_of(input logic [4:0] m);
      logic [2:0] b;
      b = 3'd0;
      case (m)
         `PEC_MODE_FIQ: b = 3'd1;
         `PEC_MODE_IRQ: b = 3'd2;
         `PEC_MODE_ABT: b = 3'd3;
         `PEC_MODE_MON: b = 3'd4;
         default:       b = 3'd0;
      endcase
      return b;
   endfunction : bank_of

   // ****************************************************************
   // Exception decision.
   // ****************************************************************
   logic              ns;              // Nonsecure state.
   logic              f_open;          // Fast request may be taken.
   logic              fiq_req;         // Fast request at boundary.
   logic              irq_req;         // Normal request at boundary.
   logic              ext_seen;        // Bus error reaches core.
   logic              ext_prec;        // Bus error is precise.
   logic              dabt_prec;       // Precise data abort now.
   logic              imp_new;         // New imprecise abort.
   logic              pabt_req;        // Prefetch abort at boundary.
   logic              iabt_req;        // Imprecise abort taken.
   logic [4:0]        fs_code;         // Fault code for this abort.
   pec_pkg::pec_exc_t nxt_kind;        // Selected entry.
   logic [4:0]        nxt_mode;        // Target mode.
   logic              to_mon;          // Entry goes to monitor.

   assign ns     = scr_ff[`PEC_SC_NS];
   // Nonsecure with the unmaskable option ignores F.
   assign f_open = !csr_ff[`PEC_SR_F] ||
                   (ns && scr_ff[`PEC_SC_FW]);
   assign fiq_req = instr_end && !fiq_q_ff && f_open;
   assign irq_req = instr_end && !irq_q_ff &&
                    !csr_ff[`PEC_SR_I];
   // A cacheable line error waits until the word itself is read.
   assign ext_seen = ext_err &&
                     (!ext_cacheable || ext_word_req);
   assign ext_prec = ext_strong || ext_ld_psr ||
                     ext_swap_ld;
   assign dabt_prec = mem_fault || (ext_seen && ext_prec);
   assign imp_new   = ext_seen && !ext_prec;
   // A flushed instruction never reaches instr_end, so no abort.
   assign pabt_req  = instr_end && ex_fetch_bad;
   assign iabt_req  = instr_end && imp_pend_ff &&
                      !csr_ff[`PEC_SR_A];

   // Fault code of the abort under way.
   always_comb
   begin
      fs_code = `PEC_FS_EXTI;
      if (mem_fault)
      begin
         case (mem_fault_cls)
            pec_pkg::PEC_FLT_ALIGN: fs_code = `PEC_FS_ALIGN;
            pec_pkg::PEC_FLT_TRANS: fs_code = `PEC_FS_TRANS;
            pec_pkg::PEC_FLT_ACCF:  fs_code = `PEC_FS_ACCF;
            pec_pkg::PEC_FLT_DOM:   fs_code = `PEC_FS_DOM;
            pec_pkg::PEC_FLT_PERM:  fs_code = `PEC_FS_PERM;
            pec_pkg::PEC_FLT_CPIM:  fs_code = `PEC_FS_CPIM;
            pec_pkg::PEC_FLT_WATCH: fs_code = `PEC_FS_WATCH;
            default:                fs_code = `PEC_FS_CACHE;
         endcase
      end
      else if (ext_seen && ext_prec)
      begin
         fs_code = `PEC_FS_EXTP;
      end
   end

   // Priority: precise data, fast, normal, prefetch, imprecise.
   always_comb
   begin
      nxt_kind = pec_pkg::PEC_EXC_NONE;
      nxt_mode = csr_ff[`PEC_SR_M_HI:`PEC_SR_M_LO];
      to_mon   = 1'b0;
      if (dabt_prec)
      begin
         nxt_kind = pec_pkg::PEC_EXC_DABT;
         to_mon   = ext_seen && !mem_fault && scr_ff[`PEC_SC_EA];
      end
      else if (fiq_req)
      begin
         nxt_kind = pec_pkg::PEC_EXC_FIQ;
         to_mon   = scr_ff[`PEC_SC_FIQ];
      end
      else if (irq_req)
      begin
         nxt_kind = pec_pkg::PEC_EXC_IRQ;
         to_mon   = scr_ff[`PEC_SC_IRQ];
      end
      else if (pabt_req)
      begin
         nxt_kind = pec_pkg::PEC_EXC_PABT;
      end
      else if (iabt_req)
      begin
         nxt_kind = pec_pkg::PEC_EXC_IABT;
         to_mon   = scr_ff[`PEC_SC_EA];
      end
      else if (ret_s_pc)
      begin
         nxt_kind = pec_pkg::PEC_EXC_RET;
      end
      case (nxt_kind)
         pec_pkg::PEC_EXC_FIQ:  nxt_mode = `PEC_MODE_FIQ;
         pec_pkg::PEC_EXC_IRQ:  nxt_mode = `PEC_MODE_IRQ;
         pec_pkg::PEC_EXC_DABT,
         pec_pkg::PEC_EXC_PABT,
         pec_pkg::PEC_EXC_IABT: nxt_mode = `PEC_MODE_ABT;
         default: nxt_mode = csr_ff[`PEC_SR_M_HI:`PEC_SR_M_LO];
      endcase
      if (to_mon)
      begin
         nxt_mode = `PEC_MODE_MON;
      end
   end

   logic entry;                 // A real exception entry.
   logic is_abt;                // Entry is any abort.
   logic [2:0] tgt_bank;        // Bank that receives the save.
   logic [2:0] cur_bank;        // Bank of the current mode.
   assign entry = nxt_kind != pec_pkg::PEC_EXC_NONE &&
                  nxt_kind != pec_pkg::PEC_EXC_RET;
   assign is_abt = nxt_kind == pec_pkg::PEC_EXC_DABT ||
                   nxt_kind == pec_pkg::PEC_EXC_PABT ||
                   nxt_kind == pec_pkg::PEC_EXC_IABT;
   assign tgt_bank = bank_of(nxt_mode);
   assign cur_bank = bank_of(csr_ff[`PEC_SR_M_HI:`PEC_SR_M_LO]);

   // ****************************************************************
   // Input registers.
   // ****************************************************************
   // Requests go through one flop; control looks only at the flop.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fiq_q_ff <= 1'b1;
         irq_q_ff <= 1'b1;
      end
      else
      begin
         fiq_q_ff <= fast_interrupt_req_n;
         irq_q_ff <= normal_interrupt_req_n;
      end
   end

   // ****************************************************************
   // Current status word.
   // ****************************************************************
   logic [31:0] sw_csr;         // Software write, filtered.
   always_comb
   begin
      sw_csr = reg_wdata;
      // T and J are not software writable.
      sw_csr[`PEC_SR_T] = csr_ff[`PEC_SR_T];
      sw_csr[`PEC_SR_J] = csr_ff[`PEC_SR_J];
      if (ns && !scr_ff[`PEC_SC_AW])
      begin
         sw_csr[`PEC_SR_A] = csr_ff[`PEC_SR_A];
      end
   end

   // Reset gives a constant; the T strap is caught after release.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         csr_ff <= `PEC_ZERO32;
         csr_ff[`PEC_SR_M_HI:`PEC_SR_M_LO] <= `PEC_MODE_SVC;
         csr_ff[`PEC_SR_A] <= 1'b1;
         csr_ff[`PEC_SR_I] <= 1'b1;
         csr_ff[`PEC_SR_F] <= 1'b1;
      end
      else if (boot_pend_ff)
      begin
         csr_ff[`PEC_SR_T] <= boot_state_select;
      end
      else if (entry)
      begin
         csr_ff[`PEC_SR_M_HI:`PEC_SR_M_LO] <= nxt_mode;
         csr_ff[`PEC_SR_I] <= 1'b1;
         csr_ff[`PEC_SR_A] <= 1'b1;
         if (nxt_kind == pec_pkg::PEC_EXC_FIQ ||
             (is_abt && to_mon))
         begin
            csr_ff[`PEC_SR_F] <= 1'b1;
         end
      end
      else if (nxt_kind == pec_pkg::PEC_EXC_RET)
      begin
         csr_ff <= ssr_ff[cur_bank];
         if (ns && !scr_ff[`PEC_SC_AW]) csr_ff[`PEC_SR_A] <= csr_ff[`PEC_SR_A];
      end
      else if (reg_wr && reg_addr == `PEC_OFF_CSR)
      begin
         csr_ff <= sw_csr;
      end
   end

   // ****************************************************************
   // Secure configuration and fault status.
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scr_ff <= `PEC_ZERO32;
      end
      else if (reg_wr && reg_addr == `PEC_OFF_SCR)
      begin
         scr_ff <= {{(32-`PEC_SC_W){1'b0}},
                    reg_wdata[`PEC_SC_W-1:0]};
      end
   end

   // Fault code is kept for the data or imprecise abort actually taken; a prefetch abort leaves it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fsr_ff <= 5'h00;
      end
      else if (entry && is_abt && nxt_kind != pec_pkg::PEC_EXC_PABT)
      begin
         fsr_ff <= (nxt_kind == pec_pkg::PEC_EXC_IABT) ?
                   `PEC_FS_EXTI : fs_code;
      end
   end

   // ****************************************************************
   // Banked saved status and link words.
   // ****************************************************************
   for (genvar g = 0; g < 5; g++)
   begin : g_bank
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            ssr_ff[g] <= `PEC_ZERO32;
            lnk_ff[g] <= '0;
         end
         else if (entry && !boot_pend_ff && tgt_bank == g)
         begin
            ssr_ff[g] <= csr_ff;
            lnk_ff[g] <= cur_pc;
         end
         else if (reg_wr && reg_addr == `PEC_OFF_SSR &&
                  cur_bank == g)
         begin
            // Saved A stays writable; it reaches live status only
            // through a return.
            ssr_ff[g] <= reg_wdata;
         end
      end
   end

   // ****************************************************************
   // Imprecise abort holding.
   // ****************************************************************
   // A new error in the cycle the old one is taken stays pending.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         imp_pend_ff <= 1'b0;
      end
      else if (imp_new)
      begin
         imp_pend_ff <= 1'b1;
      end
      else if (nxt_kind == pec_pkg::PEC_EXC_IABT && !boot_pend_ff)
      begin
         imp_pend_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // Reset sequencing.
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         boot_pend_ff <= 1'b1;
         abandon_ff   <= 1'b1;
         fetch_rv_ff  <= 1'b0;
      end
      else
      begin
         boot_pend_ff <= 1'b0;
         abandon_ff   <= 1'b0;
         fetch_rv_ff  <= boot_pend_ff;
      end
   end

   // ****************************************************************
   // Entry report and base restore.
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         taken_ff <= 1'b0;
         kind_ff  <= pec_pkg::PEC_EXC_NONE;
      end
      else
      begin
         taken_ff <= entry && !boot_pend_ff;
         kind_ff  <= boot_pend_ff ? pec_pkg::PEC_EXC_NONE : nxt_kind;
      end
   end

   // The old base wins whenever the access aborted precisely.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         base_wb_ff  <= 1'b0;
         base_val_ff <= `PEC_ZERO32;
      end
      else
      begin
         base_wb_ff  <= base_upd && instr_end;
         base_val_ff <= dabt_prec ? base_old : base_new;
      end
   end

   // ****************************************************************
   // Register read port.
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_ff <= `PEC_ZERO32;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            `PEC_OFF_SCR: rdata_ff <= scr_ff;
            `PEC_OFF_CSR: rdata_ff <= csr_ff;
            `PEC_OFF_SSR: rdata_ff <= ssr_ff[cur_bank];
            `PEC_OFF_FSR: rdata_ff <= {27'h000_0000, fsr_ff};
            `PEC_OFF_LNK: rdata_ff <= 32'(lnk_ff[cur_bank]);
            default:      rdata_ff <= `PEC_ZERO32;
         endcase
      end
      else
      begin
         rdata_ff <= `PEC_ZERO32;
      end
   end

   assign reg_rdata       = rdata_ff;
   assign status_out      = csr_ff;
   assign abandon         = abandon_ff;
   assign fetch_reset_vec = fetch_rv_ff;
   assign exc_taken       = taken_ff;
   assign exc_kind        = kind_ff;
   assign base_wb         = base_wb_ff;
   assign base_val        = base_val_ff;
endmodule : pec_exception_entry
`default_nettype wire

// File: test/pec_sva.sv
`include "pec_consts.svh"
`default_nettype none
// ****************************************************************
// Entry side effects seen at the block's ports.
// ****************************************************************
module pec_sva (
   input wire logic              clk,         // Clock.
   input wire logic              rst_n,       // Reset, low.
   input wire logic              fast_interrupt_req_n, // Fast line.
   input wire logic [31:0]       status_out,  // Status.
   input wire logic              abandon,     // Abandon.
   input wire logic              fetch_reset_vec, // Vector fetch.
   input wire logic              exc_taken,   // Entry pulse.
   input wire pec_pkg::pec_exc_t exc_kind,    // Entry kind.
   input wire logic              base_wb,     // Base write.
   input wire logic [31:0]       base_val,    // Base value.
   input wire logic [31:0]       base_old     // Old base.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Kinds decoded here; a mode check alone misses a wrong kind.
   wire logic [4:0] md  = status_out[4:0];
   wire logic       fiq = exc_taken && exc_kind == pec_pkg::PEC_EXC_FIQ;
   wire logic       irq = exc_taken && exc_kind == pec_pkg::PEC_EXC_IRQ;
   wire logic       dab = exc_taken && exc_kind == pec_pkg::PEC_EXC_DABT;
   wire logic       abt = dab || exc_taken && exc_kind inside
      {pec_pkg::PEC_EXC_PABT, pec_pkg::PEC_EXC_IABT};
   a_reset_state: assert property (abandon |->
      md == `PEC_MODE_SVC && &status_out[8:6]) else $error("reset state");
   a_boot_fetch: assert property ($fell(abandon) |->
      fetch_reset_vec && !status_out[24]) else $error("no vector fetch");
   a_fiq_masks: assert property (fiq |-> &status_out[8:6]
      && md inside {`PEC_MODE_FIQ, `PEC_MODE_MON}) else $error("fiq entry");
   a_irq_masks: assert property (irq |-> status_out[7]
      && md inside {`PEC_MODE_IRQ, `PEC_MODE_MON}) else $error("irq entry");
   a_abort_masks: assert property (abt |-> status_out[7]
      && md inside {`PEC_MODE_ABT, `PEC_MODE_MON}) else $error("abort entry");
   a_fiq_cause: assert property (fiq |->
      !$past(fast_interrupt_req_n, 2)) else $error("fiq unrequested");
   a_irq_unmasked: assert property (irq |->
      !$past(status_out[7])) else $error("irq while masked");
   a_base_restore: assert property (dab && base_wb |->
      base_val == $past(base_old)) else $error("base updated");
   c_fiq: cover property (fiq);
   c_irq: cover property (irq);
   c_dab: cover property (dab && base_wb);
endmodule : pec_sva
bind pec_exception_entry pec_sva u_sva (.clk, .rst_n, .fast_interrupt_req_n,
   .status_out, .abandon, .fetch_reset_vec, .exc_taken, .exc_kind, .base_wb,
   .base_val, .base_old);
`default_nettype wire

// File: test/pec_irq_src.sv
`default_nettype none
// ****************************************************************
// Interrupt sources: a level held low until its handler is entered.
// ****************************************************************
module pec_irq_src (
   input  wire logic              clk,    // Clock.
   input  wire logic              rst_n,  // Reset, low.
   input  wire logic              rf,     // Raise fast request.
   input  wire logic              rn,     // Raise normal request.
   input  wire logic              taken,  // Core entry pulse.
   input  wire pec_pkg::pec_exc_t kind,   // Core entry kind.
   output logic                   fast_n, // Fast line, low active.
   output logic                   norm_n  // Normal line, low active.
);
   timeunit 1ns;
   timeprecision 1ps;
   // The handler quiets the device; the drop on entry models that.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) {fast_n, norm_n} <= 2'b11;
      else
      begin
         if (rf) fast_n <= 1'b0;
         else if (taken && kind == pec_pkg::PEC_EXC_FIQ) fast_n <= 1'b1;
         if (rn) norm_n <= 1'b0;
         else if (taken && kind == pec_pkg::PEC_EXC_IRQ) norm_n <= 1'b1;
      end
   end
endmodule : pec_irq_src
`default_nettype wire

// File: test/testbench.sv
`include "pec_consts.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, boot_state_select, instr_end, ex_fetch_bad, mem_fault;
   logic ext_err, ext_strong, ext_ld_psr, ext_swap_ld, ext_cacheable;
   logic ext_word_req, base_upd, ret_s_pc, reg_wr, reg_rd, abandon, rf, rn;
   logic fetch_reset_vec, exc_taken, base_wb;
   logic fast_interrupt_req_n, normal_interrupt_req_n;
   logic [31:0] cur_pc, base_old, base_new, reg_wdata, reg_rdata;
   logic [31:0] status_out, base_val;
   logic [7:0]  reg_addr;
   pec_pkg::pec_flt_t mem_fault_cls;
   pec_pkg::pec_exc_t exc_kind;
   int num_errors = 0, n_tests = 0, cyc = 0;
   pec_exception_entry DUT (.clk, .rst_n, .boot_state_select,
      .fast_interrupt_req_n, .normal_interrupt_req_n, .instr_end, .cur_pc,
      .ex_fetch_bad, .mem_fault, .mem_fault_cls, .ext_err, .ext_strong,
      .ext_ld_psr, .ext_swap_ld, .ext_cacheable, .ext_word_req, .base_old,
      .base_new, .base_upd, .ret_s_pc, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .status_out, .abandon, .fetch_reset_vec,
      .exc_taken, .exc_kind, .base_wb, .base_val);
   pec_irq_src u_src (.clk, .rst_n, .rf, .rn, .taken(exc_taken),
      .kind(exc_kind), .fast_n(fast_interrupt_req_n),
      .norm_n(normal_interrupt_req_n));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // A hang ends the run as a failure.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask : rd
   task automatic raise(input logic f, input logic n);
      @(posedge clk) {rf, rn} <= {f, n};
      @(posedge clk) {rf, rn} <= 2'b00;
   endtask : raise
   // One retiring instruction; the entry shows after the second edge.
   task automatic step(input logic bad, input logic ret);
      @(posedge clk) {instr_end, ex_fetch_bad, ret_s_pc} <= {1'b1, bad, ret};
      @(posedge clk) {instr_end, ex_fetch_bad, ret_s_pc} <= 3'h0;
      #1;
   endtask : step
   task automatic ent(input pec_pkg::pec_exc_t k, input logic [31:0] s);
      chk("exc_taken", 32'(k != pec_pkg::PEC_EXC_RET), {31'h0, exc_taken});
      chk("exc_kind", {26'h0, k}, {26'h0, exc_kind});
      chk("status_out", s, status_out);
   endtask : ent
   initial
   begin
      {rst_n, instr_end, ex_fetch_bad, mem_fault, ext_err, rf, rn} = '0;
      {ext_strong, ext_ld_psr, ext_swap_ld, ext_cacheable, ext_word_req} = '0;
      {base_upd, ret_s_pc, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {base_old, base_new, boot_state_select} = {64'h0, 1'b1};
      cur_pc = 32'h0000_0100;
      mem_fault_cls = pec_pkg::PEC_FLT_PERM;
      repeat (16) @(posedge clk);
      #1 chk("abandon", 32'h1, {31'h0, abandon});
      chk("status_out", 32'h0000_01D3, status_out);
      @(posedge clk) rst_n <= 1'b1;
      @(posedge clk);
      #1 chk("status_out", 32'h0000_01F3, status_out);
      chk("fetch_reset_vec", 32'h1, {31'h0, fetch_reset_vec});
      rd(`PEC_OFF_SCR, 32'h0, "scr");
      $display("reset done");
      wr(`PEC_OFF_CSR, 32'h0000_0013);
      raise(1'b1, 1'b0);
      step(1'b0, 1'b0);
      ent(pec_pkg::PEC_EXC_FIQ, 32'h0000_01F1);
      rd(`PEC_OFF_SSR, 32'h0000_0033, "ssr");
      rd(`PEC_OFF_LNK, 32'h0000_0100, "link");
      raise(1'b0, 1'b1);
      step(1'b0, 1'b0);
      chk("exc_taken", 32'h0, {31'h0, exc_taken});
      wr(`PEC_OFF_CSR, 32'h0000_0011);
      step(1'b0, 1'b0);
      ent(pec_pkg::PEC_EXC_IRQ, 32'h0000_01B2);
      wr(`PEC_OFF_SCR, 32'h0000_0002);
      wr(`PEC_OFF_CSR, 32'h0000_0013);
      raise(1'b1, 1'b1);
      step(1'b0, 1'b0);
      ent(pec_pkg::PEC_EXC_FIQ, 32'h0000_01F1);
      wr(`PEC_OFF_CSR, 32'h0000_0013);
      step(1'b0, 1'b0);
      chk("irq_mode", 32'h0000_0016, {27'h0, status_out[4:0]});
      wr(`PEC_OFF_SCR, 32'h0);
      $display("interrupts done");
      wr(`PEC_OFF_CSR, 32'h0000_0013);
      @(posedge clk) {mem_fault, base_upd, instr_end, base_old, base_new} <=
         {3'b111, 32'h0000_1000, 32'h0000_1010};
      @(posedge clk) {mem_fault, base_upd, instr_end} <= 3'b000;
      #1 ent(pec_pkg::PEC_EXC_DABT, 32'h0000_01B7);
      chk("base_val", 32'h0000_1000, base_val);
      // Each precise external class in turn: strong, load to pc, swap.
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk) {ext_err, ext_strong, ext_ld_psr, ext_swap_ld} <=
            {1'b1, 3'b100 >> i};
         @(posedge clk) {ext_err, ext_strong, ext_ld_psr, ext_swap_ld} <= 4'h0;
         #1 ent(pec_pkg::PEC_EXC_DABT, 32'h0000_01B7);
      end
      wr(`PEC_OFF_SCR, 32'h0000_0001);
      wr(`PEC_OFF_CSR, 32'h0000_0097);
      rd(`PEC_OFF_CSR, 32'h0000_01B7, "csr_ns");
      wr(`PEC_OFF_SCR, 32'h0);
      @(posedge clk) ext_err <= 1'b1;
      @(posedge clk) ext_err <= 1'b0;
      step(1'b0, 1'b0);
      chk("exc_taken", 32'h0, {31'h0, exc_taken});
      wr(`PEC_OFF_CSR, 32'h0000_0097);
      step(1'b0, 1'b0);
      ent(pec_pkg::PEC_EXC_IABT, 32'h0000_01B7);
      step(1'b0, 1'b1);
      ent(pec_pkg::PEC_EXC_RET, 32'h0000_00B7);
      step(1'b1, 1'b0);
      ent(pec_pkg::PEC_EXC_PABT, 32'h0000_01B7);
      $display("aborts done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
